// File: inc/co2_readout_params.svh
// Contract
// - UART characters are 38400 baud, eight data bits, no parity, one stop bit.
// - a measurement frame goes out every 3 seconds without any host request.
// - frame is five value chars, space, 'p','p','m', then two terminator bytes.
// - every frame ends with carriage return 0x0D then line feed 0x0A.
// - value chars are right-justified ASCII decimal digits, leading positions space-filled.
// - acts only as I2C target and answers seven-bit address 0x31.
// - address byte LSB is direction; 0x63 reads, 0x62 writes.
// - host writes address then command 'R' (0x52); module acknowledges both bytes.
// - host restarts with read address and takes seven acknowledged data bytes.
// - response is configuration byte, two concentration bytes, four 0x00 bytes.
// - recalibration input held low 11 minutes starts manual zero recalibration.
// - with auto option fitted, recalibrate after 3 days, then every 30 days.
// - calibration mode is fixed at build time, never switched at run time.
// - reported value spans zero to full scale, at most 30000 ppm.
`ifndef CO2_READOUT_PARAMS_SVH
`define CO2_READOUT_PARAMS_SVH

// ****************************************
// clock and timing
// ****************************************
`define CLK_HZ              50000000
`define BAUD_RATE           38400
`define UART_CLKS_PER_BIT   (`CLK_HZ / `BAUD_RATE)
`define FRAME_PERIOD_S      3
`define MANUAL_HOLD_MIN     11
`define AUTO_FIRST_DAYS     3
`define AUTO_PERIOD_DAYS    30
`define SECONDS_PER_MIN     60
`define SECONDS_PER_DAY     86400

// ****************************************
// serial frame layout
// ****************************************
`define FRAME_LEN           11
`define FRAME_LAST_IDX      4'hA
`define VALUE_CHARS         5
`define ASCII_SPACE         8'h20
`define ASCII_ZERO          8'h30
`define ASCII_P             8'h70
`define ASCII_M             8'h6D
`define ASCII_CR            8'h0D
`define ASCII_LF            8'h0A
`define FULL_SCALE_PPM      16'h7530

// ****************************************
// i2c target
// ****************************************
`define I2C_TARGET_ADDR     7'h31
`define I2C_CMD_READ        8'h52
`define I2C_RESP_LAST_IDX   3'h6
`define I2C_RESERVED_BYTE   8'h00
`define CONFIG_BYTE_RESET   8'h00

// ****************************************
// reset values
// ****************************************
`define TXD_IDLE            1'b1

`endif

// File: inc/co2_readout_pkg.sv
package co2_readout_pkg;

	typedef enum logic [3:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_CMD,
		I2C_CMD_ACK,
		I2C_RD,
		I2C_RD_ACK,
		I2C_IGNORE
	} i2c_state_t;

	typedef struct packed {
		logic        busy;
		logic [15:0] cnt;
		logic [3:0]  bitn;
		logic [9:0]  sh;
		logic        txd;
	} uart_state_t;

	typedef struct packed {
		// frame transmitter
		logic [31:0]      frame_cnt;
		logic [10:0][7:0] frame_bytes;
		logic [3:0]       frame_idx;
		logic             frame_busy;
		logic             tx_valid;
		// i2c target
		logic             scl_prev;
		logic             sda_prev;
		i2c_state_t       ist;
		logic [3:0]       bcnt;
		logic [7:0]       sh;
		logic             rw;
		logic             host_ack;
		logic [2:0]       ridx;
		logic [7:0]       obyte;
		logic [15:0]      snap;
		logic             sda_oe;
		logic             sda_o;
		logic             cmd_pulse;
		// recalibration
		logic [47:0]      man_cnt;
		logic             man_done;
		logic [47:0]      up_cnt;
		logic             first_done;
		logic             recal_pulse;
		logic             recal_auto;
	} readout_state_t;

endpackage : co2_readout_pkg

// File: rtl/uart_byte_tx.sv
`timescale 1ns/1ps
`include "co2_readout_params.svh"

module uart_byte_tx #(
	parameter int CLKS_PER_BIT = `UART_CLKS_PER_BIT
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] byte_data,
	input  wire logic       byte_valid,
	output logic            byte_ready,
	output logic            txd
);

	co2_readout_pkg::uart_state_t s_q;
	co2_readout_pkg::uart_state_t s_d;

	assign byte_ready = !s_q.busy;
	assign txd        = s_q.txd;

	// ****************************************
	// 8N1 shifter: start, 8 data lsb first, stop
	// ****************************************
	always_comb begin
		s_d = s_q;
		if (!s_q.busy) begin
			if (byte_valid) begin
				s_d.busy = 1'b1;
				s_d.cnt  = 16'h0000;
				s_d.bitn = 4'h0;
				s_d.sh   = {1'b1, byte_data, 1'b0};
				s_d.txd  = 1'b0;
			end
		end else if (s_q.cnt == 16'(CLKS_PER_BIT - 1)) begin
			s_d.cnt = 16'h0000;
			if (s_q.bitn == 4'h9) begin
				// stop bit done; line already idles high
				s_d.busy = 1'b0;
			end else begin
				s_d.bitn = s_q.bitn + 4'h1;
				s_d.sh   = {1'b1, s_q.sh[9:1]};
				s_d.txd  = s_q.sh[1];
			end
		end else begin
			s_d.cnt = s_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '{busy: 1'b0, cnt: 16'h0000, bitn: 4'h0, sh: 10'h3FF, txd: `TXD_IDLE};
		end else begin
			s_q <= s_d;
		end
	end

endmodule : uart_byte_tx

// File: rtl/co2_sensor_serial_readout.sv
`timescale 1ns/1ps
`include "co2_readout_params.svh"

module co2_sensor_serial_readout #(
	// calibration mode is a build-time choice, never a run-time one
	parameter bit                AUTO_RECAL_OPTION = 1'b0,
	parameter logic [7:0]        CONFIG_BYTE       = `CONFIG_BYTE_RESET,
	parameter logic [15:0]       FULL_SCALE        = `FULL_SCALE_PPM,
	parameter int                CLKS_PER_BIT      = `UART_CLKS_PER_BIT,
	parameter longint unsigned   FRAME_CYCLES      = 64'(`FRAME_PERIOD_S) * 64'(`CLK_HZ),
	parameter longint unsigned   MANUAL_CYCLES     =
		64'(`MANUAL_HOLD_MIN) * 64'(`SECONDS_PER_MIN) * 64'(`CLK_HZ),
	parameter longint unsigned   AUTO_FIRST_CYCLES =
		64'(`AUTO_FIRST_DAYS) * 64'(`SECONDS_PER_DAY) * 64'(`CLK_HZ),
	parameter longint unsigned   AUTO_PERIOD_CYCLES =
		64'(`AUTO_PERIOD_DAYS) * 64'(`SECONDS_PER_DAY) * 64'(`CLK_HZ)
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [15:0] ppm_value,
	input  wire logic        manual_recal_request_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             uart_txd,
	output logic             read_cmd_seen,
	output logic             recal_pulse,
	output logic             recal_auto
);

	co2_readout_pkg::readout_state_t s_q;
	co2_readout_pkg::readout_state_t s_d;

	logic       tx_ready;
	logic       scl_rise;
	logic       scl_fall;
	logic       i2c_start;
	logic       i2c_stop;
	logic [15:0] ppm_clamped;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [4:0][7:0] value_chars(input logic [15:0] v);
		logic [15:0]      r;
		logic [4:0][7:0]  c;
		r = v;
		c = '0;
		for (int i = 4; i >= 0; i--) begin
			// leading zeros become spaces; the last position always shows a digit
			if (r == 16'h0000 && i != 4) begin
				c[i] = `ASCII_SPACE;
			end else begin
				c[i] = `ASCII_ZERO + 8'(r % 16'h000A);
			end
			r = r / 16'h000A;
		end
		return c;
	endfunction : value_chars

	function automatic logic [7:0] resp_byte(input logic [2:0] idx, input logic [15:0] v);
		logic [7:0] b;
		b = `I2C_RESERVED_BYTE;
		if (idx == 3'h0) begin
			b = CONFIG_BYTE;
		end else if (idx == 3'h1) begin
			b = v[15:8];
		end else if (idx == 3'h2) begin
			b = v[7:0];
		end
		return b;
	endfunction : resp_byte

	// values above the fitted range are reported at full scale
	assign ppm_clamped = (ppm_value > FULL_SCALE) ? FULL_SCALE : ppm_value;

	// ****************************************
	// i2c line events
	// ****************************************
	// start and stop only occur with scl high; our own pull-down moves sda only while scl is low
	assign scl_rise  = scl_in && !s_q.scl_prev;
	assign scl_fall  = !scl_in && s_q.scl_prev;
	assign i2c_start = scl_in && s_q.scl_prev && s_q.sda_prev && !sda_in;
	assign i2c_stop  = scl_in && s_q.scl_prev && !s_q.sda_prev && sda_in;

	// ****************************************
	// byte serialiser
	// ****************************************
	uart_byte_tx #(
		.CLKS_PER_BIT (CLKS_PER_BIT)
	) u_tx (
		.mclk       (mclk),
		.rst        (rst),
		.byte_data  (s_q.frame_bytes[s_q.frame_idx]),
		.byte_valid (s_q.tx_valid),
		.byte_ready (tx_ready),
		.txd        (uart_txd)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [4:0][7:0] chars;
		logic [7:0]      first_byte;
		logic [7:0]      next_byte;
		chars       = value_chars(ppm_clamped);
		first_byte  = resp_byte(3'h0, s_q.snap);
		next_byte   = resp_byte(s_q.ridx + 3'h1, s_q.snap);
		s_d         = s_q;
		s_d.scl_prev    = scl_in;
		s_d.sda_prev    = sda_in;
		s_d.cmd_pulse   = 1'b0;
		s_d.recal_pulse = 1'b0;

		// ---- periodic frame, no handshake with the host ----
		// no back-pressure: a host that is not listening simply misses the frame
		// counter runs from reset, so the first frame leaves one period after release
		if (s_q.frame_cnt == 32'(FRAME_CYCLES - 1)) begin
			s_d.frame_cnt = 32'h0000_0000;
			// a frame lasts a few ms, so the previous one is always done here
			if (!s_q.frame_busy) begin
				s_d.frame_bytes[0]  = chars[0];
				s_d.frame_bytes[1]  = chars[1];
				s_d.frame_bytes[2]  = chars[2];
				s_d.frame_bytes[3]  = chars[3];
				s_d.frame_bytes[4]  = chars[4];
				s_d.frame_bytes[5]  = `ASCII_SPACE;
				s_d.frame_bytes[6]  = `ASCII_P;
				s_d.frame_bytes[7]  = `ASCII_P;
				s_d.frame_bytes[8]  = `ASCII_M;
				s_d.frame_bytes[9]  = `ASCII_CR;
				s_d.frame_bytes[10] = `ASCII_LF;
				s_d.frame_idx   = 4'h0;
				s_d.frame_busy  = 1'b1;
				s_d.tx_valid    = 1'b1;
			end
		end else begin
			s_d.frame_cnt = s_q.frame_cnt + 32'h0000_0001;
		end
		if (s_q.tx_valid && tx_ready) begin
			if (s_q.frame_idx == `FRAME_LAST_IDX) begin
				s_d.tx_valid   = 1'b0;
				s_d.frame_busy = 1'b0;
			end else begin
				s_d.frame_idx = s_q.frame_idx + 4'h1;
			end
		end

		// ---- i2c target; never drives scl, only pulls sda low ----
		if (i2c_stop) begin
			s_d.ist    = co2_readout_pkg::I2C_IDLE;
			s_d.sda_oe = 1'b0;
		end else if (i2c_start) begin
			s_d.ist    = co2_readout_pkg::I2C_ADDR;
			s_d.bcnt   = 4'h0;
			s_d.sda_oe = 1'b0;
		end else begin
			case (s_q.ist)
				co2_readout_pkg::I2C_ADDR: begin
					if (scl_rise) begin
						s_d.sh   = {s_q.sh[6:0], sda_in};
						s_d.bcnt = s_q.bcnt + 4'h1;
					end else if (scl_fall && s_q.bcnt == 4'h8) begin
						if (s_q.sh[7:1] == `I2C_TARGET_ADDR) begin
							s_d.rw     = s_q.sh[0];
							s_d.sda_oe = 1'b1;
							s_d.ist    = co2_readout_pkg::I2C_ADDR_ACK;
						end else begin
							s_d.ist = co2_readout_pkg::I2C_IGNORE;
						end
					end
				end
				co2_readout_pkg::I2C_ADDR_ACK: begin
					if (scl_fall) begin
						if (s_q.rw) begin
							// a read with no command first returns the last snapshot
							s_d.ridx   = 3'h0;
							s_d.obyte  = first_byte;
							s_d.sda_oe = !first_byte[7];
							s_d.bcnt   = 4'h1;
							s_d.ist    = co2_readout_pkg::I2C_RD;
						end else begin
							s_d.sda_oe = 1'b0;
							s_d.bcnt   = 4'h0;
							s_d.ist    = co2_readout_pkg::I2C_CMD;
						end
					end
				end
				co2_readout_pkg::I2C_CMD: begin
					if (scl_rise) begin
						s_d.sh   = {s_q.sh[6:0], sda_in};
						s_d.bcnt = s_q.bcnt + 4'h1;
					end else if (scl_fall && s_q.bcnt == 4'h8) begin
						if (s_q.sh == `I2C_CMD_READ) begin
							// snapshot so all seven bytes belong to one reading
							s_d.snap      = ppm_clamped;
							s_d.cmd_pulse = 1'b1;
							s_d.sda_oe    = 1'b1;
							s_d.ist       = co2_readout_pkg::I2C_CMD_ACK;
						end else begin
							s_d.ist = co2_readout_pkg::I2C_IGNORE;
						end
					end
				end
				co2_readout_pkg::I2C_CMD_ACK: begin
					if (scl_fall) begin
						// one command byte only; anything more is left unacknowledged
						s_d.sda_oe = 1'b0;
						s_d.ist    = co2_readout_pkg::I2C_IGNORE;
					end
				end
				co2_readout_pkg::I2C_RD: begin
					if (scl_fall) begin
						if (s_q.bcnt == 4'h8) begin
							s_d.sda_oe = 1'b0;
							s_d.ist    = co2_readout_pkg::I2C_RD_ACK;
						end else begin
							s_d.sda_oe = !s_q.obyte[3'(4'h7 - s_q.bcnt)];
							s_d.bcnt   = s_q.bcnt + 4'h1;
						end
					end
				end
				co2_readout_pkg::I2C_RD_ACK: begin
					if (scl_rise) begin
						s_d.host_ack = !sda_in;
					end else if (scl_fall) begin
						if (s_q.host_ack && s_q.ridx != `I2C_RESP_LAST_IDX) begin
							s_d.ridx   = s_q.ridx + 3'h1;
							s_d.obyte  = next_byte;
							s_d.sda_oe = !next_byte[7];
							s_d.bcnt   = 4'h1;
							s_d.ist    = co2_readout_pkg::I2C_RD;
						end else begin
							// past the seventh byte the bus reads as released
							s_d.ist = co2_readout_pkg::I2C_IGNORE;
						end
					end
				end
				default: begin
					s_d.sda_oe = 1'b0;
				end
			endcase
		end

		// ---- manual zero recalibration ----
		// releasing the pin re-arms; a request held far longer still fires once
		if (manual_recal_request_n) begin
			s_d.man_cnt  = 48'h0;
			s_d.man_done = 1'b0;
		end else if (!s_q.man_done) begin
			if (s_q.man_cnt == 48'(MANUAL_CYCLES - 1)) begin
				s_d.man_done    = 1'b1;
				s_d.recal_pulse = 1'b1;
				s_d.recal_auto  = 1'b0;
			end else begin
				s_d.man_cnt = s_q.man_cnt + 48'h1;
			end
		end

		// ---- automatic recalibration, present only when fitted ----
		// 48-bit counters cover the thirty-day period at the full clock rate
		if (AUTO_RECAL_OPTION) begin
			if ((!s_q.first_done && s_q.up_cnt == 48'(AUTO_FIRST_CYCLES - 1)) ||
			    (s_q.first_done && s_q.up_cnt == 48'(AUTO_PERIOD_CYCLES - 1))) begin
				s_d.up_cnt      = 48'h0;
				s_d.first_done  = 1'b1;
				s_d.recal_pulse = 1'b1;
				s_d.recal_auto  = 1'b1;
			end else begin
				s_d.up_cnt = s_q.up_cnt + 48'h1;
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			// idle bus levels, so no false start follows reset
			s_q             <= '0;
			s_q.scl_prev    <= 1'b1;
			s_q.sda_prev    <= 1'b1;
			s_q.ist         <= co2_readout_pkg::I2C_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// open drain: only the enable moves, the driven level stays low
	assign sda_out       = s_q.sda_o;
	assign sda_oe        = s_q.sda_oe;
	assign read_cmd_seen = s_q.cmd_pulse;
	assign recal_pulse   = s_q.recal_pulse;
	assign recal_auto    = s_q.recal_auto;

endmodule : co2_sensor_serial_readout

// File: testbench/co2_readout_assertions.sv
`timescale 1ns/1ps
// ***
// port checks
// ***
module co2_readout_assertions #(
	parameter int              CLKS_PER_BIT       = 8,
	parameter longint unsigned MANUAL_CYCLES      = 100,
	parameter longint unsigned AUTO_FIRST_CYCLES  = 200,
	parameter longint unsigned AUTO_PERIOD_CYCLES = 500
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic manual_recal_request_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic uart_txd,
	input wire logic read_cmd_seen,
	input wire logic recal_pulse,
	input wire logic recal_auto
);
	logic        txd_p_q;
	logic        seen_q;
	logic [31:0] run_q;
	logic [31:0] man_q;
	logic [31:0] gap_q;
	// run_q holds the length of the txd run ending one sample back
	always_ff @(posedge mclk) begin
		if (rst) begin
			txd_p_q <= 1'h1;
			seen_q  <= 1'h0;
			run_q   <= 32'h0;
			man_q   <= 32'h0;
			gap_q   <= 32'h0;
		end else begin
			txd_p_q <= uart_txd;
			seen_q  <= seen_q | (recal_pulse & recal_auto);
			run_q   <= (uart_txd != txd_p_q) ? 32'h1 : run_q + 32'h1;
			man_q   <= manual_recal_request_n ? 32'h0 : man_q + 32'h1;
			gap_q   <= (recal_pulse & recal_auto) ? 32'h1 : gap_q + 32'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_open_drain; sda_out == 1'h0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_oe_low_scl; $changed(sda_oe) |-> !scl_in; endproperty
	a_oe_low_scl: assert property (p_oe_low_scl) else $error("sda moved while scl high");
	property p_cmd_ack; read_cmd_seen |-> sda_oe ##1 !read_cmd_seen; endproperty
	a_cmd_ack: assert property (p_cmd_ack) else $error("command not acked");
	property p_bit_time; $rose(uart_txd) |-> run_q != 32'h0 && run_q % CLKS_PER_BIT == 0; endproperty
	a_bit_time: assert property (p_bit_time) else $error("bad low run");
	property p_stop_min; $fell(uart_txd) |-> run_q >= CLKS_PER_BIT; endproperty
	a_stop_min: assert property (p_stop_min) else $error("short high run");
	property p_man_time;
		recal_pulse && !recal_auto |-> man_q >= MANUAL_CYCLES && man_q <= MANUAL_CYCLES + 2;
	endproperty
	a_man_time: assert property (p_man_time) else $error("manual recal early or late");
	property p_man_due; man_q == MANUAL_CYCLES && !manual_recal_request_n |-> ##[0:3] recal_pulse; endproperty
	a_man_due: assert property (p_man_due) else $error("manual recal missing");
	property p_auto_time;
		recal_pulse && recal_auto |-> seen_q ? gap_q == AUTO_PERIOD_CYCLES
			: gap_q >= AUTO_FIRST_CYCLES - 1 && gap_q <= AUTO_FIRST_CYCLES + 2;
	endproperty
	a_auto_time: assert property (p_auto_time) else $error("auto recal off time");
	c_cmd: cover property (read_cmd_seen);
	c_man: cover property (recal_pulse && !recal_auto);
	c_auto: cover property (recal_pulse && recal_auto);
endmodule : co2_readout_assertions

bind co2_sensor_serial_readout co2_readout_assertions #(
	.CLKS_PER_BIT      (CLKS_PER_BIT),
	.MANUAL_CYCLES     (MANUAL_CYCLES),
	.AUTO_FIRST_CYCLES (AUTO_FIRST_CYCLES),
	.AUTO_PERIOD_CYCLES(AUTO_PERIOD_CYCLES)
) i_chk (
	.mclk                  (mclk),
	.rst                   (rst),
	.manual_recal_request_n(manual_recal_request_n),
	.scl_in                (scl_in),
	.sda_out               (sda_out),
	.sda_oe                (sda_oe),
	.uart_txd              (uart_txd),
	.read_cmd_seen         (read_cmd_seen),
	.recal_pulse           (recal_pulse),
	.recal_auto            (recal_auto)
);

// File: testbench/co2_host_model.sv
`timescale 1ns/1ps
// ***
// host: i2c controller and uart listener
// ***
module co2_host_model #(
	parameter int HALF = 8,
	parameter int CPB  = 8
) (
	input  wire logic mclk,
	input  wire logic sda_in,
	input  wire logic uart_txd,
	output logic      scl_out,
	output logic      sda_low
);
	logic [7:0] frame_b [11];
	logic [7:0] rx_b;
	int         nb = 0;
	int         n_frames = 0;
	int         stop_err = 0;
	time        sof_t = 0;
	time        sof_prev_t = 0;
	initial begin
		scl_out = 1'h1;
		sda_low = 1'h0;
	end
	// scl and the per-byte gap are scaled far below a real host's timing to keep runs short
	task automatic half();
		repeat (HALF) @(negedge mclk);
	endtask : half
	task automatic i2c_start();
		sda_low = 1'h1;
		half();
		scl_out = 1'h0;
	endtask : i2c_start
	task automatic i2c_stop();
		half();
		sda_low = 1'h1;
		half();
		scl_out = 1'h1;
		half();
		sda_low = 1'h0;
		half();
	endtask : i2c_stop
	task automatic clk_bit(output logic s);
		half();
		scl_out = 1'h1;
		s = sda_in;
		half();
		scl_out = 1'h0;
	endtask : clk_bit
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_low = !b[i];
			clk_bit(s);
		end
		sda_low = 1'h0;
		clk_bit(s);
		ack = !s;
	endtask : wr_byte
	task automatic rd_byte(input logic ack_it, output logic [7:0] b);
		logic s;
		repeat (4 * HALF) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			clk_bit(s);
			b = {b[6:0], s};
		end
		sda_low = ack_it;
		clk_bit(s);
		sda_low = 1'h0;
	endtask : rd_byte
	always begin
		@(negedge uart_txd);
		if (nb == 0) begin
			sof_prev_t = sof_t;
			sof_t = $time;
		end
		repeat (CPB / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (CPB) @(posedge mclk);
			rx_b[i] = uart_txd;
		end
		repeat (CPB) @(posedge mclk);
		if (uart_txd !== 1'h1) stop_err++;
		frame_b[nb] = rx_b;
		nb = (nb + 1) % 11;
		if (nb == 0) n_frames++;
	end
endmodule : co2_host_model

// File: testbench/co2_sensor_serial_readout_bench.sv
`timescale 1ns/1ps
// ***
// bench
// ***
module co2_sensor_serial_readout_bench;
	localparam int         CPB   = 8;
	localparam int         FRAME = 2000;
	localparam logic [7:0] CFG   = 8'hA5;
	logic        mclk;
	logic        rst;
	logic [15:0] ppm_value;
	logic        manual_recal_request_n;
	logic        scl;
	logic        sda_low;
	logic        sda_out;
	logic        sda_oe;
	logic        uart_txd;
	logic        read_cmd_seen;
	logic        recal_pulse;
	logic        recal_auto;
	logic        fx_pulse;
	logic        fx_auto;
	logic [15:0] rnd;
	wire         sda_w;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          n_man = 0;
	int          n_auto = 0;
	int          last_auto = 0;
	int          n_cmd = 0;
	int          n_fx_man = 0;
	int          n_fx_auto = 0;
	// pull-up: low while either side pulls
	assign sda_w = (sda_oe ? sda_out : 1'h1) & !sda_low;
	co2_sensor_serial_readout #(
		.AUTO_RECAL_OPTION (1'h1),
		.CONFIG_BYTE       (CFG),
		.CLKS_PER_BIT      (CPB),
		.FRAME_CYCLES      (FRAME),
		.MANUAL_CYCLES     (100),
		.AUTO_FIRST_CYCLES (200),
		.AUTO_PERIOD_CYCLES(500)
	) i_dut (
		.mclk                  (mclk),
		.rst                   (rst),
		.ppm_value             (ppm_value),
		.manual_recal_request_n(manual_recal_request_n),
		.scl_in                (scl),
		.sda_in                (sda_w),
		.sda_out               (sda_out),
		.sda_oe                (sda_oe),
		.uart_txd              (uart_txd),
		.read_cmd_seen         (read_cmd_seen),
		.recal_pulse           (recal_pulse),
		.recal_auto            (recal_auto)
	);
	co2_host_model #(.HALF(8), .CPB(CPB)) i_host (
		.mclk    (mclk),
		.sda_in  (sda_w),
		.uart_txd(uart_txd),
		.scl_out (scl),
		.sda_low (sda_low)
	);
	// second build: no auto recalibration, manual only, i2c left idle
	co2_sensor_serial_readout #(
		.AUTO_RECAL_OPTION (1'h0),
		.CONFIG_BYTE       (CFG),
		.CLKS_PER_BIT      (CPB),
		.FRAME_CYCLES      (FRAME),
		.MANUAL_CYCLES     (100),
		.AUTO_FIRST_CYCLES (200),
		.AUTO_PERIOD_CYCLES(500)
	) i_fixed (
		.mclk                  (mclk),
		.rst                   (rst),
		.ppm_value             (ppm_value),
		.manual_recal_request_n(manual_recal_request_n),
		.scl_in                (1'h1),
		.sda_in                (1'h1),
		.sda_out               (),
		.sda_oe                (),
		.uart_txd              (),
		.read_cmd_seen         (),
		.recal_pulse           (fx_pulse),
		.recal_auto            (fx_auto)
	);
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	function automatic int clampv(input int v);
		return (v > 30000) ? 30000 : v;
	endfunction : clampv
	function automatic logic [7:0] fr_byte(input int v, input int i);
		int d;
		d = clampv(v);
		case (i)
			5: return 8'h20;
			6, 7: return 8'h70;
			8: return 8'h6D;
			9: return 8'h0D;
			10: return 8'h0A;
			default: ;
		endcase
		if (i < 4 && d < 10 ** (4 - i)) return 8'h20;
		return 8'(8'h30 + (d / 10 ** (4 - i)) % 10);
	endfunction : fr_byte
	function automatic logic [7:0] rsp_byte(input int v, input int i);
		int d;
		d = clampv(v);
		case (i)
			0: return CFG;
			1: return 8'(d >> 8);
			2: return 8'(d);
			default: return 8'h00;
		endcase
	endfunction : rsp_byte
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic i2c_read(input int v);
		logic       a;
		logic [7:0] b;
		i_host.i2c_start();
		i_host.wr_byte(8'h62, a);
		check(a, 32'h1);
		i_host.wr_byte(8'h52, a);
		check(a, 32'h1);
		i_host.i2c_stop();
		i_host.i2c_start();
		i_host.wr_byte(8'h63, a);
		check(a, 32'h1);
		for (int i = 0; i < 7; i++) begin
			i_host.rd_byte(1'h1, b);
			check(b, rsp_byte(v, i));
		end
		i_host.i2c_stop();
	endtask : i2c_read
	// the second completed frame is the second launched after the new value
	task automatic chk_frame(input int v);
		int f0;
		f0 = i_host.n_frames;
		while (i_host.n_frames < f0 + 2) @(negedge mclk);
		for (int i = 0; i < 11; i++) check(i_host.frame_b[i], fr_byte(v, i));
		check(32'(i_host.sof_t - i_host.sof_prev_t), 32'(FRAME * 20));
	endtask : chk_frame
	always @(negedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			give_verdict();
		end
		if (!rst && recal_pulse === 1'h1) begin
			if (recal_auto === 1'h1) begin
				if (n_auto > 0) check(cyc - last_auto, 32'h1F4);
				n_auto++;
				last_auto = cyc;
			end else begin
				n_man++;
			end
		end
		if (!rst && read_cmd_seen === 1'h1) n_cmd++;
		if (!rst && fx_pulse === 1'h1) begin
			if (fx_auto === 1'h0) n_fx_man++;
			else n_fx_auto++;
		end
	end
	initial begin
		logic a;
		int   v;
		int   vals [4];
		vals = '{0, 7, 30000, 40000};
		rst = 1'h1;
		ppm_value = 16'h0;
		manual_recal_request_n = 1'h1;
		rnd = 16'h5FEC;
		repeat (4) @(negedge mclk);
		rst = 1'h0;
		manual_recal_request_n = 1'h0;
		repeat (50) @(negedge mclk);
		manual_recal_request_n = 1'h1;
		repeat (5) @(negedge mclk);
		manual_recal_request_n = 1'h0;
		repeat (250) @(negedge mclk);
		manual_recal_request_n = 1'h1;
		check(n_man, 32'h1);
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			v = (k < 4) ? vals[k] : int'(rnd);
			ppm_value = 16'(v);
			i2c_read(v);
			chk_frame(v);
		end
		i_host.i2c_start();
		i_host.wr_byte(8'h64, a);
		check(a, 32'h0);
		i_host.i2c_stop();
		i_host.i2c_start();
		i_host.wr_byte(8'h62, a);
		check(a, 32'h1);
		i_host.wr_byte(8'h41, a);
		check(a, 32'h0);
		i_host.i2c_stop();
		check(32'(n_auto > 3), 32'h1);
		check(i_host.stop_err, 32'h0);
		check(n_cmd, 32'h6);
		check(n_fx_man, 32'h1);
		check(n_fx_auto, 32'h0);
		give_verdict();
	end
endmodule : co2_sensor_serial_readout_bench
